// ==== bench/srh_ctrl_model.sv ====
`timescale 1ns/1ps
module srh_ctrl_model (
  // Clock.
  input  wire logic              mclk,
  // Request and answer.
  output srh_pkg::srh_req_t      req,
  input  wire srh_pkg::srh_rsp_t rsp
);
  import srh_pkg::*;

  initial req = '0;

  // Holds the request through its taking edge and takes the answer where it stands.
  task automatic xfer(input srh_cmd_t c, input logic [15:0] w, output logic [15:0] d);
    int n;
    n = 0;
    d = 16'hFFFF;
    @(posedge mclk);
    req <= '{valid: 1'b1, cmd: c, wdata: w};
    @(posedge mclk);
    req <= '{valid: 1'b0, cmd: CMD_NONE, wdata: ~w};
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.valid !== 1'b1 && n < 4);
    if (rsp.valid === 1'b1) d = rsp.data;
  endtask : xfer
endmodule : srh_ctrl_model

// ==== bench/test_status_reporting_hierarchy.sv ====
`timescale 1ns/1ps
module test_status_reporting_hierarchy;
  import srh_pkg::*;
  logic           mclk = 1'b0;
  logic           rst_b = 1'b0;
  srh_normal_ops_summary_cond_t operCond = '0;
  srh_irregular_summary_cond_t quesCond = '0;
  srh_std_evt_t   stdEvt = '0;
  logic           replyWaiting = 1'b0;
  logic           errPush = 1'b0;
  logic [15:0]    errCode = 16'h0000;
  srh_req_t       req;
  srh_rsp_t       rsp;
  logic           serviceRequestLine;
  logic           serviceSummaryLive;
  int             num_errors = 0;
  int             n_checks = 0;
  int             cycles = 0;

  always #2.5 mclk = ~mclk;

  srh_status_core #(.ERR_DEPTH(4)) i_srh_status_core (
    .mclk(mclk), .rst_b(rst_b), .operCond(operCond), .quesCond(quesCond),
    .stdEvt(stdEvt), .replyWaiting(replyWaiting), .errPush(errPush),
    .errCode(errCode), .req(req), .rsp(rsp),
    .serviceRequestLine(serviceRequestLine), .serviceSummaryLive(serviceSummaryLive));
  srh_ctrl_model i_srh_ctrl_model (.mclk(mclk), .req(req), .rsp(rsp));

  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input srh_cmd_t c, input logic [15:0] w);
    logic [15:0] d;
    i_srh_ctrl_model.xfer(c, w, d);
  endtask : wr

  task automatic rd(input srh_cmd_t c, input logic [15:0] exp);
    logic [15:0] d;
    i_srh_ctrl_model.xfer(c, 16'h0000, d);
    chk(d, exp);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  ////////////////////////////////////////
  task automatic t_powerup();
    rd(CMD_RD_STB, 16'h0000);
    rd(CMD_RD_STD_EVT, 16'h0080);
    rd(CMD_RD_STD_EVT, 16'h0000);
    $display("t_powerup done");
  endtask : t_powerup

  task automatic t_normal_ops_summary();
    @(posedge mclk) operCond <= 4'hF;
    tick(2);
    wr(CMD_WR_NORMAL_OPS_SUMMARY_EN, 16'h0010);
    rd(CMD_RD_NORMAL_OPS_SUMMARY_COND, 16'h0170);
    rd(CMD_RD_NORMAL_OPS_SUMMARY_COND, 16'h0170);
    rd(CMD_RD_STB, 16'h0080);
    rd(CMD_RD_NORMAL_OPS_SUMMARY_EVT, 16'h0170);
    rd(CMD_RD_NORMAL_OPS_SUMMARY_EVT, 16'h0000);
    rd(CMD_RD_STB, 16'h0000);
    wr(CMD_WR_NORMAL_OPS_SUMMARY_RISE, 16'h0000);
    wr(CMD_WR_NORMAL_OPS_SUMMARY_FALL, 16'h0100);
    @(posedge mclk) operCond <= 4'h0;
    tick(2);
    @(posedge mclk) operCond <= 4'hF;
    tick(2);
    rd(CMD_RD_NORMAL_OPS_SUMMARY_EVT, 16'h0100);
    rd(CMD_RD_NORMAL_OPS_SUMMARY_EN, 16'h0010);
    rd(CMD_RD_NORMAL_OPS_SUMMARY_FALL, 16'h0100);
    $display("t_normal_ops_summary done");
  endtask : t_normal_ops_summary

  task automatic t_irregular_summary();
    @(posedge mclk) quesCond <= '1;
    tick(2);
    wr(CMD_WR_IRREGULAR_SUMMARY_EN, 16'h4000);
    rd(CMD_RD_IRREGULAR_SUMMARY_COND, 16'h7F7F);
    rd(CMD_RD_STB, 16'h0008);
    rd(CMD_RD_IRREGULAR_SUMMARY_EVT, 16'h7F7F);
    rd(CMD_RD_STB, 16'h0000);
    $display("t_irregular_summary done");
  endtask : t_irregular_summary

  task automatic t_std();
    wr(CMD_WR_STD_EN, 16'h0020);
    rd(CMD_RD_STB, 16'h0000);
    @(posedge mclk) stdEvt <= '1;
    @(posedge mclk) stdEvt <= '0;
    tick(1);
    rd(CMD_RD_STB, 16'h0020);
    rd(CMD_RD_STD_EVT, 16'h003D);
    rd(CMD_RD_STB, 16'h0000);
    $display("t_std done");
  endtask : t_std

  task automatic t_srq();
    @(posedge mclk) replyWaiting <= 1'b1;
    rd(CMD_RD_STB, 16'h0010);
    wr(CMD_WR_SRE, 16'h0010);
    tick(1);
    chk({15'h0, serviceSummaryLive}, 16'h0001);
    chk({15'h0, serviceRequestLine}, 16'h0001);
    rd(CMD_RD_STB, 16'h0050);
    chk({15'h0, serviceRequestLine}, 16'h0001);
    rd(CMD_SERIAL_POLL, 16'h0050);
    tick(2);
    chk({15'h0, serviceRequestLine}, 16'h0000);
    rd(CMD_SERIAL_POLL, 16'h0010);
    @(posedge mclk) replyWaiting <= 1'b0;
    wr(CMD_WR_SRE, 16'h0000);
    $display("t_srq done");
  endtask : t_srq

  task automatic t_errq();
    for (int i = 1; i <= 5; i++) begin
      @(posedge mclk);
      errPush <= 1'b1;
      errCode <= 16'(i);
    end
    @(posedge mclk) errPush <= 1'b0;
    tick(1);
    rd(CMD_RD_STB, 16'h0004);
    for (int i = 1; i <= 3; i++) rd(CMD_RD_ERROR, 16'(i));
    rd(CMD_RD_ERROR, ERR_OVERFLOW_CODE);
    rd(CMD_RD_ERROR, ERR_NONE_CODE);
    rd(CMD_RD_STB, 16'h0000);
    $display("t_errq done");
  endtask : t_errq

  task automatic t_regs();
    wr(CMD_WR_IRREGULAR_SUMMARY_RISE, 16'hFFFF);
    wr(CMD_WR_IRREGULAR_SUMMARY_FALL, 16'h8080);
    wr(CMD_WR_NORMAL_OPS_SUMMARY_RISE, 16'h0030);
    wr(CMD_WR_STD_EN, 16'h00A5);
    wr(CMD_WR_SRE, 16'h00FF);
    rd(CMD_RD_IRREGULAR_SUMMARY_RISE, 16'h7F7F);
    rd(CMD_RD_IRREGULAR_SUMMARY_FALL, 16'h0000);
    rd(CMD_RD_NORMAL_OPS_SUMMARY_RISE, 16'h0030);
    rd(CMD_RD_IRREGULAR_SUMMARY_EN, 16'h4000);
    rd(CMD_RD_STD_EN, 16'h00A5);
    rd(CMD_RD_SRE, 16'h00BC);
    @(posedge mclk) errPush <= 1'b1;
    @(posedge mclk) errPush <= 1'b0;
    stdEvt <= 5'h01;
    @(posedge mclk) stdEvt <= '0;
    tick(1);
    rd(CMD_RD_STB, 16'h0064);
    chk({15'h0, serviceSummaryLive}, 16'h0001);
    wr(CMD_CLEAR_STATUS, 16'h0000);
    chk({15'h0, serviceSummaryLive}, 16'h0000);
    rd(CMD_RD_STB, 16'h0000);
    rd(CMD_SERIAL_POLL, 16'h0040);
    rd(CMD_RD_ERROR, ERR_NONE_CODE);
    rd(CMD_RD_STD_EVT, 16'h0000);
    tick(1);
    chk({15'h0, serviceRequestLine}, 16'h0000);
    @(posedge mclk) rst_b <= 1'b0;
    tick(2);
    @(posedge mclk) rst_b <= 1'b1;
    rd(CMD_RD_STD_EVT, 16'h0080);
    rd(CMD_RD_NORMAL_OPS_SUMMARY_EVT, 16'h0170);
    rd(CMD_RD_IRREGULAR_SUMMARY_EVT, 16'h7F7F);
    rd(CMD_RD_SRE, 16'h0000);
    $display("t_regs done");
  endtask : t_regs

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    t_powerup();
    t_normal_ops_summary();
    t_irregular_summary();
    t_std();
    t_srq();
    t_errq();
    t_regs();
    summarize();
  end
endmodule : test_status_reporting_hierarchy

// ==== core/srh_err_queue.sv ====
`timescale 1ns/1ps
module srh_err_queue #(
  parameter int WIDTH = srh_pkg::ERR_W,
  parameter int DEPTH = srh_pkg::ERR_DEPTH
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // Store and remove.
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] pushCode,
  input  wire logic             pop,
  input  wire logic             flush,
  // State.
  output logic      [WIDTH-1:0] headCode,
  output logic                  notEmpty
);
  import srh_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    rdPtr_ff, wrPtr_ff, nxt_rdPtr, nxt_wrPtr;
  logic [CW-1:0]    count_ff, nxt_count;
  logic             wrEn;
  logic [PW-1:0]    wrAddr;
  logic [WIDTH-1:0] wrData;
  logic             full;
  logic             doPop;

  assign full     = (count_ff == FULL_CNT);
  assign notEmpty = (count_ff != '0);
  assign headCode = mem[rdPtr_ff];
  assign doPop    = pop && notEmpty;

  always_comb begin
    nxt_rdPtr = rdPtr_ff;
    nxt_wrPtr = wrPtr_ff;
    nxt_count = count_ff;
    wrEn      = 1'b0;
    wrAddr    = wrPtr_ff;
    wrData    = pushCode;
    if (flush) begin
      nxt_rdPtr = '0;
      nxt_wrPtr = '0;
      nxt_count = '0;
    end else begin
      if (doPop) begin
        nxt_rdPtr = rdPtr_ff + 1'b1;
      end
      if (push && (!full || doPop)) begin
        wrEn      = 1'b1;
        nxt_wrPtr = wrPtr_ff + 1'b1;
      end else if (push) begin
        // A full queue keeps its oldest entries; the newest becomes the overflow code.
        wrEn   = 1'b1;
        wrAddr = wrPtr_ff - 1'b1;
        wrData = ERR_OVERFLOW_CODE;
      end
      nxt_count = count_ff + CW'(wrEn && (nxt_wrPtr != wrPtr_ff)) - CW'(doPop);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdPtr_ff <= '0;
      wrPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      rdPtr_ff <= nxt_rdPtr;
      wrPtr_ff <= nxt_wrPtr;
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  a_overflow_replace: assert property (@(posedge mclk) disable iff (!rst_b)
    (push && full && !pop && !flush) |=> (mem[wrPtr_ff - 1'b1] == ERR_OVERFLOW_CODE)
      && (count_ff == FULL_CNT))
    else $error("overflow did not replace newest error entry");

endmodule : srh_err_queue

// ==== core/srh_pkg.sv ====
package srh_pkg;

  // Register widths and error queue depth.
  localparam int COND_W  = 16;
  localparam int BYTE_W  = 8;
  localparam int ERR_W   = 16;
  localparam int ERR_DEPTH = 8;

  // Status byte bit positions.
  localparam int STB_EEQ_BIT  = 2;
  localparam int STB_IRREGULAR_SUMMARY_BIT = 3;
  localparam int STB_MAV_BIT  = 4;
  localparam int STB_ESB_BIT  = 5;
  localparam int STB_RQS_BIT  = 6;
  localparam int STB_NORMAL_OPS_SUMMARY_BIT = 7;

  // Standard event bit positions.
  localparam int SE_OPS_DONE_BIT  = 0;
  localparam int SE_QUERY_ERR_BIT = 2;
  localparam int SE_DEVICE_ERR_BIT = 3;
  localparam int SE_RUN_FAIL_BIT  = 4;
  localparam int SE_SYNTAX_ERR_BIT = 5;
  localparam int SE_POWERUP_BIT   = 7;

  // Implemented bits of each word; the others read as zero, except in the operation, questionable and standard enables.
  localparam logic [COND_W-1:0] NORMAL_OPS_SUMMARY_USED_MASK = 16'h0170;
  localparam logic [COND_W-1:0] IRREGULAR_SUMMARY_USED_MASK = 16'h7F7F;
  localparam logic [BYTE_W-1:0] STD_USED_MASK  = 8'hBD;
  localparam logic [BYTE_W-1:0] STB_SRE_MASK   = 8'hBC;

  // Values after reset.
  localparam logic [COND_W-1:0] RISE_FILTER_RST = 16'hFFFF;
  localparam logic [COND_W-1:0] FALL_FILTER_RST = 16'h0000;
  localparam logic [COND_W-1:0] ENABLE16_RST    = 16'h0000;
  localparam logic [BYTE_W-1:0] ENABLE8_RST     = 8'h00;
  localparam logic [BYTE_W-1:0] STD_EVENT_RST   = 8'h80;

  // Error queue codes, two's complement.
  localparam logic [ERR_W-1:0] ERR_OVERFLOW_CODE = 16'hFEA2;
  localparam logic [ERR_W-1:0] ERR_NONE_CODE     = 16'h0000;

  typedef enum logic [4:0] {
    CMD_NONE          = 5'h00,
    CMD_RD_NORMAL_OPS_SUMMARY_COND  = 5'h01,
    CMD_RD_NORMAL_OPS_SUMMARY_EVT   = 5'h02,
    CMD_RD_NORMAL_OPS_SUMMARY_EN    = 5'h03,
    CMD_WR_NORMAL_OPS_SUMMARY_EN    = 5'h04,
    CMD_RD_NORMAL_OPS_SUMMARY_RISE  = 5'h05,
    CMD_WR_NORMAL_OPS_SUMMARY_RISE  = 5'h06,
    CMD_RD_NORMAL_OPS_SUMMARY_FALL  = 5'h07,
    CMD_WR_NORMAL_OPS_SUMMARY_FALL  = 5'h08,
    CMD_RD_IRREGULAR_SUMMARY_COND  = 5'h09,
    CMD_RD_IRREGULAR_SUMMARY_EVT   = 5'h0A,
    CMD_RD_IRREGULAR_SUMMARY_EN    = 5'h0B,
    CMD_WR_IRREGULAR_SUMMARY_EN    = 5'h0C,
    CMD_RD_IRREGULAR_SUMMARY_RISE  = 5'h0D,
    CMD_WR_IRREGULAR_SUMMARY_RISE  = 5'h0E,
    CMD_RD_IRREGULAR_SUMMARY_FALL  = 5'h0F,
    CMD_WR_IRREGULAR_SUMMARY_FALL  = 5'h10,
    CMD_RD_STD_EVT    = 5'h11,
    CMD_RD_STD_EN     = 5'h12,
    CMD_WR_STD_EN     = 5'h13,
    CMD_RD_SRE        = 5'h14,
    CMD_WR_SRE        = 5'h15,
    CMD_RD_STB        = 5'h16,
    CMD_SERIAL_POLL   = 5'h17,
    CMD_RD_ERROR      = 5'h18,
    CMD_CLEAR_STATUS  = 5'h19
  } srh_cmd_t;

  typedef struct packed {
    logic measActive;
    logic awaitAcquireTrigger;
    logic awaitTransientTrigger;
    logic constantVoltageMode;
  } srh_normal_ops_summary_cond_t;

  typedef struct packed {
    logic overvoltageTrip;
    logic overcurrentTrip;
    logic hardwareFault;
    logic lowVoltage;
    logic overtempTrip;
    logic ioInactivityTrip;
    logic externalBlockActive;
    logic calibrationFail;
    logic overpowerTrip;
    logic peakCurrentClamp;
    logic powerClamp;
    logic effectiveCurrentClamp;
    logic senseFault;
    logic meterOverrange;
  } srh_irregular_summary_cond_t;

  typedef struct packed {
    logic opsDoneFlag;
    logic queryError;
    logic deviceError;
    logic runFailure;
    logic syntaxError;
  } srh_std_evt_t;

  typedef struct packed {
    logic              valid;
    srh_cmd_t          cmd;
    logic [COND_W-1:0] wdata;
  } srh_req_t;

  typedef struct packed {
    logic              valid;
    logic [COND_W-1:0] data;
  } srh_rsp_t;

endpackage : srh_pkg

// ==== core/srh_status_core.sv ====
// Functional notes
// - Status bit 7 ORs enabled operation events
// - Operation bits 4,5,6: measuring, awaiting triggers
// - Operation bit 8 set in constant voltage
// - Status bit 3 ORs enabled questionable events
// - Questionable bits 0,1,2,4: protection shutdowns
// - Questionable bits 3,5,6: low voltage, watchdog, inhibit
// - Questionable bits 8..14 limits and faults; 7,15 zero
// - Standard event register read-only, cleared on read
// - Standard bit 0 when all operations done
// - Standard bit 2 on query errors
// - Standard bits 3,4,5 errors; 1,6 zero
// - Standard bit 7 set at power-up
// - Status bits 0 and 1 read zero
// - Status bit 2 while error queue nonempty
// - Status bit 4 while replies await
// - Status bit 5 ORs enabled standard events
// - Live summary ORs status bits with enables
// - Status query returns live summary, no side effects
// - Service request drives line, latches bit 6
// - Serial poll returns and clears latched request
// - Error queue FIFO, overflow replaces newest entry
// - Condition words live, read without side effect
// - Event bits latch transitions until read
// - Rise and fall filters select reported edges
// - Enable registers keep written values; the service request enable drops bits 0,1,6
`timescale 1ns/1ps
module srh_status_core #(
  parameter int ERR_DEPTH = srh_pkg::ERR_DEPTH
) (
  // Clock and reset.
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  // Condition sources.
  input  wire srh_pkg::srh_normal_ops_summary_cond_t operCond,
  input  wire srh_pkg::srh_irregular_summary_cond_t quesCond,
  input  wire srh_pkg::srh_std_evt_t   stdEvt,
  input  wire logic                    replyWaiting,
  // Error queue feed.
  input  wire logic                    errPush,
  input  wire logic [15:0]             errCode,
  // Controller requests and answers.
  input  wire srh_pkg::srh_req_t       req,
  output srh_pkg::srh_rsp_t            rsp,
  // Service request.
  output logic                         serviceRequestLine,
  output logic                         serviceSummaryLive
);
  import srh_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////////////////////

  function automatic logic [COND_W-1:0] evalEvents(
    input logic [COND_W-1:0] cond,
    input logic [COND_W-1:0] prev,
    input logic [COND_W-1:0] rise,
    input logic [COND_W-1:0] fall
  );
    evalEvents = ((cond & ~prev & rise) | (~cond & prev & fall));
  endfunction : evalEvents

  logic [COND_W-1:0] operWord, quesWord;
  logic [COND_W-1:0] operPrev_ff, quesPrev_ff, operEvt_ff, quesEvt_ff;
  logic [COND_W-1:0] operEn_ff, quesEn_ff, operRise_ff, quesRise_ff, operFall_ff, quesFall_ff;
  logic [COND_W-1:0] nxt_operEvt, nxt_quesEvt, nxt_operEn, nxt_quesEn;
  logic [COND_W-1:0] nxt_operRise, nxt_quesRise, nxt_operFall, nxt_quesFall;
  logic [COND_W-1:0] operHit, quesHit;
  logic [BYTE_W-1:0] stdEvt_ff, nxt_stdEvt, stdEn_ff, nxt_stdEn, sre_ff, nxt_sre;
  logic [BYTE_W-1:0] stdSet, stbWord;
  logic              rqs_ff, nxt_rqs, mssPrev_ff, service_summary_live, mssRise;
  logic              errNotEmpty, errPop, clearAll;
  logic [15:0]       errHead;
  srh_rsp_t          rsp_ff, nxt_rsp;
  logic              isCmd;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Live condition words.

  assign operWord = {7'h00, operCond.constantVoltageMode, 1'b0,
                     operCond.awaitTransientTrigger, operCond.awaitAcquireTrigger,
                     operCond.measActive, 4'h0};
  assign quesWord = {1'b0, quesCond.meterOverrange, quesCond.senseFault,
                     quesCond.effectiveCurrentClamp, quesCond.powerClamp,
                     quesCond.peakCurrentClamp, quesCond.overpowerTrip,
                     quesCond.calibrationFail, 1'b0,
                     quesCond.externalBlockActive, quesCond.ioInactivityTrip,
                     quesCond.overtempTrip, quesCond.lowVoltage,
                     quesCond.hardwareFault, quesCond.overcurrentTrip,
                     quesCond.overvoltageTrip};

  assign operHit = evalEvents(operWord, operPrev_ff, operRise_ff, operFall_ff);
  assign quesHit = evalEvents(quesWord, quesPrev_ff, quesRise_ff, quesFall_ff);

  // Each standard event pulse sets its own bit of the latch.
  assign stdSet = (BYTE_W'(stdEvt.opsDoneFlag) << SE_OPS_DONE_BIT)
                | (BYTE_W'(stdEvt.queryError)  << SE_QUERY_ERR_BIT)
                | (BYTE_W'(stdEvt.deviceError) << SE_DEVICE_ERR_BIT)
                | (BYTE_W'(stdEvt.runFailure)  << SE_RUN_FAIL_BIT)
                | (BYTE_W'(stdEvt.syntaxError) << SE_SYNTAX_ERR_BIT);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Status byte and service request.

  always_comb begin
    stbWord                = 8'h00;
    stbWord[STB_NORMAL_OPS_SUMMARY_BIT]  = |(operEvt_ff & operEn_ff);
    stbWord[STB_RQS_BIT]   = rqs_ff;
    stbWord[STB_ESB_BIT]   = |(stdEvt_ff & stdEn_ff);
    stbWord[STB_MAV_BIT]   = replyWaiting;
    stbWord[STB_IRREGULAR_SUMMARY_BIT]  = |(quesEvt_ff & quesEn_ff);
    stbWord[STB_EEQ_BIT]   = errNotEmpty;
  end

  assign service_summary_live                = |(stbWord & sre_ff & STB_SRE_MASK);
  assign mssRise            = service_summary_live && !mssPrev_ff;
  assign serviceSummaryLive = service_summary_live;
  assign serviceRequestLine = rqs_ff;
  assign rsp                = rsp_ff;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Request handling and register updates.

  assign isCmd    = req.valid;
  assign clearAll = isCmd && (req.cmd == CMD_CLEAR_STATUS);
  assign errPop   = isCmd && (req.cmd == CMD_RD_ERROR);

  always_comb begin
    nxt_operEn   = operEn_ff;
    nxt_quesEn   = quesEn_ff;
    nxt_operRise = operRise_ff;
    nxt_quesRise = quesRise_ff;
    nxt_operFall = operFall_ff;
    nxt_quesFall = quesFall_ff;
    nxt_stdEn    = stdEn_ff;
    nxt_sre      = sre_ff;
    nxt_operEvt  = operEvt_ff;
    nxt_quesEvt  = quesEvt_ff;
    nxt_stdEvt   = stdEvt_ff;
    nxt_rqs      = rqs_ff;
    nxt_rsp      = '0;
    if (isCmd) begin
      nxt_rsp.valid = 1'b1;
      case (req.cmd)
        CMD_RD_NORMAL_OPS_SUMMARY_COND: nxt_rsp.data = operWord;
        CMD_RD_NORMAL_OPS_SUMMARY_EVT: begin
          nxt_rsp.data = operEvt_ff;
          nxt_operEvt  = '0;
        end
        CMD_RD_NORMAL_OPS_SUMMARY_EN:   nxt_rsp.data = operEn_ff;
        CMD_WR_NORMAL_OPS_SUMMARY_EN:   nxt_operEn   = req.wdata;
        CMD_RD_NORMAL_OPS_SUMMARY_RISE: nxt_rsp.data = operRise_ff;
        CMD_WR_NORMAL_OPS_SUMMARY_RISE: nxt_operRise = req.wdata & NORMAL_OPS_SUMMARY_USED_MASK;
        CMD_RD_NORMAL_OPS_SUMMARY_FALL: nxt_rsp.data = operFall_ff;
        CMD_WR_NORMAL_OPS_SUMMARY_FALL: nxt_operFall = req.wdata & NORMAL_OPS_SUMMARY_USED_MASK;
        CMD_RD_IRREGULAR_SUMMARY_COND: nxt_rsp.data = quesWord;
        CMD_RD_IRREGULAR_SUMMARY_EVT: begin
          nxt_rsp.data = quesEvt_ff;
          nxt_quesEvt  = '0;
        end
        CMD_RD_IRREGULAR_SUMMARY_EN:   nxt_rsp.data = quesEn_ff;
        CMD_WR_IRREGULAR_SUMMARY_EN:   nxt_quesEn   = req.wdata;
        CMD_RD_IRREGULAR_SUMMARY_RISE: nxt_rsp.data = quesRise_ff;
        CMD_WR_IRREGULAR_SUMMARY_RISE: nxt_quesRise = req.wdata & IRREGULAR_SUMMARY_USED_MASK;
        CMD_RD_IRREGULAR_SUMMARY_FALL: nxt_rsp.data = quesFall_ff;
        CMD_WR_IRREGULAR_SUMMARY_FALL: nxt_quesFall = req.wdata & IRREGULAR_SUMMARY_USED_MASK;
        CMD_RD_STD_EVT: begin
          nxt_rsp.data = {8'h00, stdEvt_ff};
          nxt_stdEvt   = '0;
        end
        CMD_RD_STD_EN:    nxt_rsp.data = {8'h00, stdEn_ff};
        CMD_WR_STD_EN:    nxt_stdEn    = req.wdata[BYTE_W-1:0];
        CMD_RD_SRE:       nxt_rsp.data = {8'h00, sre_ff};
        CMD_WR_SRE:       nxt_sre      = req.wdata[BYTE_W-1:0] & STB_SRE_MASK;
        CMD_RD_STB: begin
          nxt_rsp.data = {8'h00, stbWord};
          nxt_rsp.data[STB_RQS_BIT] = service_summary_live;
        end
        CMD_SERIAL_POLL: begin
          nxt_rsp.data = {8'h00, stbWord};
          nxt_rqs      = 1'b0;
        end
        CMD_RD_ERROR:     nxt_rsp.data = errNotEmpty ? errHead : ERR_NONE_CODE;
        CMD_CLEAR_STATUS: begin
          nxt_operEvt = '0;
          nxt_quesEvt = '0;
          nxt_stdEvt  = '0;
        end
        default:          nxt_rsp.valid = 1'b0;
      endcase
    end
    // New events are applied after any clear so that a set in the same cycle wins.
    nxt_operEvt = (nxt_operEvt | operHit) & NORMAL_OPS_SUMMARY_USED_MASK;
    nxt_quesEvt = (nxt_quesEvt | quesHit) & IRREGULAR_SUMMARY_USED_MASK;
    nxt_stdEvt  = (nxt_stdEvt | stdSet) & STD_USED_MASK;
    nxt_rqs     = nxt_rqs | mssRise;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      operPrev_ff <= '0;
      quesPrev_ff <= '0;
      operEvt_ff  <= '0;
      quesEvt_ff  <= '0;
      operEn_ff   <= ENABLE16_RST;
      quesEn_ff   <= ENABLE16_RST;
      operRise_ff <= RISE_FILTER_RST & NORMAL_OPS_SUMMARY_USED_MASK;
      quesRise_ff <= RISE_FILTER_RST & IRREGULAR_SUMMARY_USED_MASK;
      operFall_ff <= FALL_FILTER_RST;
      quesFall_ff <= FALL_FILTER_RST;
      stdEvt_ff   <= STD_EVENT_RST;
      stdEn_ff    <= ENABLE8_RST;
      sre_ff      <= ENABLE8_RST;
      rqs_ff      <= 1'b0;
      mssPrev_ff  <= 1'b0;
      rsp_ff      <= '0;
    end else begin
      operPrev_ff <= operWord;
      quesPrev_ff <= quesWord;
      operEvt_ff  <= nxt_operEvt;
      quesEvt_ff  <= nxt_quesEvt;
      operEn_ff   <= nxt_operEn;
      quesEn_ff   <= nxt_quesEn;
      operRise_ff <= nxt_operRise;
      quesRise_ff <= nxt_quesRise;
      operFall_ff <= nxt_operFall;
      quesFall_ff <= nxt_quesFall;
      stdEvt_ff   <= nxt_stdEvt;
      stdEn_ff    <= nxt_stdEn;
      sre_ff      <= nxt_sre;
      rqs_ff      <= nxt_rqs;
      mssPrev_ff  <= service_summary_live;
      rsp_ff      <= nxt_rsp;
    end
  end

  srh_err_queue #(
    .WIDTH (ERR_W),
    .DEPTH (ERR_DEPTH)
  ) u_err_queue (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .push     (errPush),
    .pushCode (errCode),
    .pop      (errPop),
    .flush    (clearAll),
    .headCode (errHead),
    .notEmpty (errNotEmpty)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_normal_ops_summary_summary: assert property ((|(operEvt_ff & operEn_ff)) |->
      stbWord[STB_NORMAL_OPS_SUMMARY_BIT] && (operEn_ff != '0))
    else $error("operation summary bit not driven by enabled events");

  a_irregular_summary_summary: assert property (stbWord[STB_IRREGULAR_SUMMARY_BIT] |-> (quesEvt_ff & quesEn_ff) != '0)
    else $error("questionable summary set without enabled event");

  a_stb_reserved_zero: assert property (stbWord[1:0] == 2'b00)
    else $error("status byte reserved bits not zero");

  a_normal_ops_summary_edge_latch: assert property ((operHit != '0) |=>
      ((operEvt_ff & $past(operHit)) == $past(operHit)))
    else $error("qualified operation transition not latched");

  a_std_read_clears: assert property ((isCmd && req.cmd == CMD_RD_STD_EVT && stdSet == '0)
      |=> (stdEvt_ff == 8'h00) && (rsp_ff.data[7:0] == $past(stdEvt_ff)))
    else $error("standard event read did not return and clear");

  a_std_unused_zero: assert property ((stdEvt_ff & ~STD_USED_MASK) == 8'h00)
    else $error("standard event unused bit set");

  a_stb_query_live: assert property ((isCmd && req.cmd == CMD_RD_STB)
      |=> rsp_ff.valid && (rsp_ff.data[STB_RQS_BIT] == $past(service_summary_live))
        && (rqs_ff == $past(rqs_ff) || $past(mssRise)))
    else $error("status query wrong summary or side effect");

  a_poll_clears_rqs: assert property ((isCmd && req.cmd == CMD_SERIAL_POLL && !mssRise)
      |=> !rqs_ff && (rsp_ff.data[STB_RQS_BIT] == $past(rqs_ff)))
    else $error("serial poll did not return and clear request");

  a_request_on_rise: assert property (mssRise |=> rqs_ff && serviceRequestLine)
    else $error("rising summary did not raise service request");

  a_no_rerequest: assert property ((!rqs_ff && mssPrev_ff && service_summary_live) |=> !rqs_ff)
    else $error("service request raised while summary held high");

  a_eeq_mav_bits: assert property ((stbWord[STB_EEQ_BIT] == errNotEmpty)
      && (stbWord[STB_MAV_BIT] == replyWaiting))
    else $error("queue status bits wrong");

  a_cond_read_live: assert property ((isCmd && req.cmd == CMD_RD_IRREGULAR_SUMMARY_COND)
      |=> (rsp_ff.data == $past(quesWord)) && (quesEvt_ff & ~$past(quesHit)) ==
        ($past(quesEvt_ff) & ~$past(quesHit)))
    else $error("condition read wrong or had a side effect");

  a_enable_kept: assert property ((isCmd && req.cmd == CMD_WR_IRREGULAR_SUMMARY_EN)
      |=> (quesEn_ff == $past(req.wdata)))
    else $error("enable register lost written value");

endmodule : srh_status_core
